//--- src/pei_params.svh
// constants of the phy event interrupt logic: register numbers, fields, resets
// assumes inclusion by bare name from the design files
`ifndef PEI_PARAMS_SVH
`define PEI_PARAMS_SVH

// ------------------------------------------------------------
// management register numbers
// ------------------------------------------------------------
`define PEI_REG_CTRL 5'h17
`define PEI_REG_MASK 5'h18
`define PEI_REG_STAT 5'h19

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define PEI_FORCE_BIT 0
`define PEI_IRQ_EN_BIT 0
`define PEI_BIT_CABLE 10
`define PEI_BIT_SYNC 9
`define PEI_MASK_RST 11'h000
`define PEI_LATCH_RST 10'h000
`define PEI_FORCE_RST 1'h0

// ------------------------------------------------------------
// management frame
// ------------------------------------------------------------
`define PEI_PRE_LEN 6'h20
`define PEI_OP_RD 2'h2
`define PEI_OP_WR 2'h1
`define PEI_OP_CNT 4'h1
`define PEI_ADDR_CNT 4'h9
`define PEI_TA_CNT 4'h1
`define PEI_DATA_CNT 4'hf

`endif

//--- src/pei_pkg.sv
// types of the phy event interrupt logic
// assumes nothing of its surroundings
package pei_pkg;

  // ------------------------------------------------------------
  // management frame decoder states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PEI_IDLE,
    PEI_START,
    PEI_OP,
    PEI_ADDR,
    PEI_TA,
    PEI_DATA
  } pei_state_e;

endpackage

//--- src/pei_sync.sv
// two flip-flop synchroniser for one pin level
// assumes a pin from outside the system clock domain
module pei_sync (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_async,
  output logic o_sync
);

  logic meta_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      meta_reg <= 1'h1;
      o_sync <= 1'h1;
    end else if (i_clk_en) begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule // pei_sync

//--- src/pei_top.sv
// event interrupt registers of a phy behind a serial management slave
// assumes event levels on the system clock, mdc and mdio from the pins
//
// Contract
// - set mask bit lets its event interrupt
// - enable bit plus pending drives pin low
// - event bits latch high until cleared
// - events at status bits eight to one
// - bit ten latches on cable test completion
// - bit nine latches on management sync loss
// - bit zero shows any enabled pending event
// - mask bits ten and nine enable those
// - force bit asserts the interrupt pin
`include "pei_params.svh"

module pei_top import pei_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe_n,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_preamble_suppress,
  input wire logic [8:1] i_event,
  input wire logic i_cable_test_done,
  output logic o_phy_irq_out_n
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic f_pending(input logic [10:1] lat, input logic [10:0] msk);
    f_pending = |(lat & msk[10:1]);
  endfunction
  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  logic mdc_s;
  logic mdio_s;
  logic mdc_d_reg;
  logic mdc_rise;
  pei_sync u_sync_mdc (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_mdc),
    .o_sync(mdc_s)
  );
  pei_sync u_sync_mdio (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_mdio),
    .o_sync(mdio_s)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mdc_d_reg <= 1'h1;
    end else if (i_clk_en) begin
      mdc_d_reg <= mdc_s;
    end
  end

  assign mdc_rise = i_clk_en & mdc_s & ~mdc_d_reg;
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pei_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [5:0] ones_cnt_reg;
  logic need_pre_reg;
  logic [1:0] op_reg;
  logic [9:0] addr_reg;
  logic [15:0] shift_reg;
  logic [10:0] mask_reg;
  logic force_reg;
  logic [10:1] latch_reg;
  logic [1:0] op_next;
  logic frame_hit;
  logic pre_ok;
  logic sync_lost;
  logic rd_take;
  logic rd_clr;
  logic wr_commit;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic [10:1] latch_set;

  assign op_next = {op_reg[0], mdio_s};
  assign frame_hit = addr_reg[9:5] == i_phy_addr;
  assign pre_ok = (ones_cnt_reg == `PEI_PRE_LEN) | (i_preamble_suppress & ~need_pre_reg);
  // a bad start or opcode means we lost frame alignment
  assign sync_lost = mdc_rise & (((state_reg == PEI_START) & ~mdio_s) |
                     ((state_reg == PEI_OP) & (bit_cnt_reg == `PEI_OP_CNT) &
                      (op_next != `PEI_OP_RD) & (op_next != `PEI_OP_WR)));
  assign rd_take = mdc_rise & (state_reg == PEI_TA) & (bit_cnt_reg == 4'h0) &
                   (op_reg == `PEI_OP_RD) & frame_hit;
  assign rd_clr = rd_take & (addr_reg[4:0] == `PEI_REG_STAT);
  assign wr_commit = mdc_rise & (state_reg == PEI_DATA) & (bit_cnt_reg == `PEI_DATA_CNT) &
                     (op_reg == `PEI_OP_WR) & frame_hit;
  assign wr_word = {shift_reg[14:0], mdio_s};
  assign latch_set = {i_cable_test_done, sync_lost, i_event};

  always_comb begin
    rd_word = 16'h0000;
    unique case (addr_reg[4:0])
      `PEI_REG_CTRL: rd_word[`PEI_FORCE_BIT] = force_reg;
      `PEI_REG_MASK: rd_word[10:0] = mask_reg;
      `PEI_REG_STAT: rd_word[10:0] = {latch_reg, f_pending(latch_reg, mask_reg)};
      default: rd_word = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // frame decoder
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_reg <= PEI_IDLE;
      bit_cnt_reg <= 4'h0;
      ones_cnt_reg <= 6'h00;
      op_reg <= 2'h0;
      addr_reg <= 10'h000;
    end else if (mdc_rise) begin
      unique case (state_reg)
        PEI_IDLE: begin
          if (mdio_s) begin
            if (ones_cnt_reg != `PEI_PRE_LEN) begin
              ones_cnt_reg <= ones_cnt_reg + 6'h01;
            end
          end else begin
            ones_cnt_reg <= 6'h00;
            if (pre_ok) begin
              state_reg <= PEI_START;
            end
          end
        end
        PEI_START: begin
          bit_cnt_reg <= 4'h0;
          state_reg <= mdio_s ? PEI_OP : PEI_IDLE;
        end
        PEI_OP: begin
          op_reg <= op_next;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `PEI_OP_CNT) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= sync_lost ? PEI_IDLE : PEI_ADDR;
          end
        end
        PEI_ADDR: begin
          addr_reg <= {addr_reg[8:0], mdio_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `PEI_ADDR_CNT) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= PEI_TA;
          end
        end
        PEI_TA: begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `PEI_TA_CNT) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= PEI_DATA;
          end
        end
        PEI_DATA: begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `PEI_DATA_CNT) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= PEI_IDLE;
          end
        end
      endcase
    end
  end

  // after a loss only a full preamble realigns us
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      need_pre_reg <= 1'h0;
    end else if (i_clk_en) begin
      if (sync_lost) begin
        need_pre_reg <= 1'h1;
      end else if (ones_cnt_reg == `PEI_PRE_LEN) begin
        need_pre_reg <= 1'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // data shifter and mdio drive
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      shift_reg <= 16'h0000;
    end else if (rd_take) begin
      shift_reg <= rd_word;
    end else if (mdc_rise & ((state_reg == PEI_DATA) |
                 ((state_reg == PEI_TA) & (bit_cnt_reg == `PEI_TA_CNT)))) begin
      shift_reg <= wr_word;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_mdio <= 1'h1;
      o_mdio_oe_n <= 1'h1;
    end else if (rd_take) begin
      o_mdio <= 1'h0;
      o_mdio_oe_n <= 1'h0;
    end else if (mdc_rise & ~o_mdio_oe_n) begin
      if ((state_reg == PEI_DATA) & (bit_cnt_reg == `PEI_DATA_CNT)) begin
        o_mdio <= 1'h1;
        o_mdio_oe_n <= 1'h1;
      end else begin
        o_mdio <= shift_reg[15];
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mask_reg <= `PEI_MASK_RST;
      force_reg <= `PEI_FORCE_RST;
    end else if (wr_commit) begin
      if (addr_reg[4:0] == `PEI_REG_MASK) begin
        mask_reg <= wr_word[10:0];
      end
      if (addr_reg[4:0] == `PEI_REG_CTRL) begin
        force_reg <= wr_word[`PEI_FORCE_BIT];
      end
    end
  end

  // set wins over the read clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      latch_reg <= `PEI_LATCH_RST;
    end else if (i_clk_en) begin
      latch_reg <= (rd_clr ? 10'h000 : latch_reg) | latch_set;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_phy_irq_out_n <= 1'h1;
    end else if (i_clk_en) begin
      o_phy_irq_out_n <= ~(force_reg | (mask_reg[`PEI_IRQ_EN_BIT] &
                           f_pending(latch_reg, mask_reg)));
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd_turn;
    rd_take;
  endsequence
  sequence s_driven_zero;
    !o_mdio_oe_n && !o_mdio;
  endsequence
  chk_masked_quiet: assert property (i_clk_en && !force_reg &&
    ((latch_reg & mask_reg[10:1]) == 10'h000) |=> o_phy_irq_out_n)
    else $error("irq asserted without enabled event");
  chk_pin_disabled: assert property (i_clk_en && !force_reg && !mask_reg[0] |=>
    o_phy_irq_out_n) else $error("irq asserted while pin disabled");
  chk_pin_assert: assert property (i_clk_en && mask_reg[0] &&
    f_pending(latch_reg, mask_reg) |=> !o_phy_irq_out_n)
    else $error("irq not asserted for pending event");
  chk_event_latch: assert property (i_clk_en && (i_event != 8'h00) |=>
    ((latch_reg[8:1] & $past(i_event)) == $past(i_event)))
    else $error("event bit not latched");
  chk_latch_hold: assert property (i_clk_en && !rd_clr |=>
    ((latch_reg & $past(latch_reg)) == $past(latch_reg)))
    else $error("latched bit lost without read");
  chk_cable_latch: assert property (i_clk_en && i_cable_test_done |=>
    latch_reg[`PEI_BIT_CABLE]) else $error("cable test completion not latched");
  chk_sync_latch: assert property (sync_lost |=>
    latch_reg[`PEI_BIT_SYNC] && need_pre_reg) else $error("sync loss not latched");
  chk_force_pin: assert property (i_clk_en && force_reg |=> !o_phy_irq_out_n)
    else $error("force bit did not assert irq");
  chk_read_clear: assert property (rd_clr && (latch_set == 10'h000) |=>
    latch_reg == 10'h000) else $error("status read did not clear");
  chk_mask_write: assert property (wr_commit && (addr_reg[4:0] == `PEI_REG_MASK) |=>
    mask_reg == $past(wr_word[10:0]))
    else $error("mask write not stored");
  chk_read_turn: assert property (s_rd_turn |=> s_driven_zero)
    else $error("turnaround zero not driven");

endmodule // pei_top

//--- test/pei_smc_model.sv
// station management controller model driving mdc and mdio frames
// assumes a pulled-up mdio wire resolved by the bench
module pei_smc_model (
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe_n = 1'b1;
  end
  // optional full preamble then one frame; mdc still between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, input logic full);
    logic [31:0] bits;
    bits = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = full ? 0 : 32; i < 64; i++) begin
      o_mdio_oe_n = (i >= 46) && (op == 2'h2);
      o_mdio = (i < 32) ? 1'b1 : bits[63 - i];
      #400 o_mdc = 1'b1;
      if (i >= 48) rd[63 - i] = i_mdio;
      #400 o_mdc = 1'b0;
    end
    o_mdio_oe_n = 1'b1;
    o_mdio = 1'b1;
  endtask
endmodule // pei_smc_model

//--- test/tb_top.sv
// self-checking bench of the phy event interrupt logic
// assumes the design files and the controller model are compiled first
`include "pei_params.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] PHY = 5'h03;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [8:1] i_event = 8'h00;
  logic i_cable_test_done = 1'b0;
  logic clk_en = 1'b1;
  logic i_preamble_suppress = 1'b0;
  logic mdc, h_mdio, h_oe_n, d_mdio, d_oe_n, mdio, irq_n;
  logic [15:0] rdat;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // pulled-up wire
  assign mdio = !d_oe_n ? d_mdio : (!h_oe_n ? h_mdio : 1'b1);
  always #50 i_clk_sys = ~i_clk_sys;
  pei_top pei_top_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
    .i_mdc(mdc), .i_mdio(mdio), .o_mdio(d_mdio), .o_mdio_oe_n(d_oe_n), .i_phy_addr(PHY),
    .i_preamble_suppress(i_preamble_suppress), .i_event(i_event),
    .i_cable_test_done(i_cable_test_done), .o_phy_irq_out_n(irq_n));
  pei_smc_model pei_smc_model_inst (.i_mdio(mdio), .o_mdc(mdc), .o_mdio(h_mdio),
    .o_mdio_oe_n(h_oe_n));

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rd(input logic [4:0] r);
    pei_smc_model_inst.frame(`PEI_OP_RD, PHY, r, 16'h0000, rdat, 1'b1);
  endtask
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] x;
    pei_smc_model_inst.frame(`PEI_OP_WR, PHY, r, d, x, 1'b1);
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge i_clk_sys) #1;
    i_event = m[8:1];
    i_cable_test_done = m[10];
    @(posedge i_clk_sys) #1;
    i_event = 8'h00;
    i_cable_test_done = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic t_reset();
    rd(`PEI_REG_MASK); `CHK(rdat, 16'h0000)
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0000)
    rd(`PEI_REG_CTRL); `CHK(rdat, 16'h0000)
    `CHK(irq_n, 1'b1)
    wr(`PEI_REG_MASK, 16'hffff);
    rd(`PEI_REG_MASK); `CHK(rdat, 16'h07ff)
  endtask
  task automatic t_events();
    wr(`PEI_REG_MASK, 16'h07fe);
    for (int i = 1; i <= 10; i++) begin
      if (i != 9) begin
        pulse(11'h001 << i);
        `CHK(irq_n, 1'b1)
        rd(`PEI_REG_STAT); `CHK(rdat, (16'h0001 << i) | 16'h0001)
        rd(`PEI_REG_STAT); `CHK(rdat, 16'h0000)
      end
    end
  endtask
  task automatic t_gate();
    wr(`PEI_REG_MASK, 16'h0005);
    pulse(11'h008);
    `CHK(irq_n, 1'b1)
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0008)
    pulse(11'h004);
    `CHK(irq_n, 1'b0)
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0005)
    `CHK(irq_n, 1'b1)
  endtask
  task automatic t_force();
    wr(`PEI_REG_MASK, 16'h0000);
    wr(`PEI_REG_CTRL, 16'h0001);
    `CHK(irq_n, 1'b0)
    rd(`PEI_REG_CTRL); `CHK(rdat, 16'h0001)
    wr(`PEI_REG_CTRL, 16'h0000);
    `CHK(irq_n, 1'b1)
  endtask
  task automatic t_sync();
    wr(`PEI_REG_MASK, 16'h0200);
    pei_smc_model_inst.frame(2'h0, PHY, `PEI_REG_STAT, 16'h0000, rdat, 1'b1);
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0201)
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0000)
  endtask
  task automatic t_persist();
    @(posedge i_clk_sys) #1;
    i_event[5] = 1'b1;
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0020)
    @(posedge i_clk_sys) #1;
    i_event[5] = 1'b0;
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0020)
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0000)
  endtask
  task automatic t_suppress();
    @(posedge i_clk_sys) #1;
    i_preamble_suppress = 1'b1;
    pei_smc_model_inst.frame(`PEI_OP_WR, PHY, `PEI_REG_MASK, 16'h0200, rdat, 1'b0);
    pei_smc_model_inst.frame(`PEI_OP_RD, PHY, `PEI_REG_MASK, 16'h0000, rdat, 1'b0);
    `CHK(rdat, 16'h0200)
    pei_smc_model_inst.frame(2'h3, PHY, `PEI_REG_STAT, 16'h0000, rdat, 1'b0);
    pei_smc_model_inst.frame(`PEI_OP_RD, PHY, `PEI_REG_STAT, 16'h0000, rdat, 1'b0);
    `CHK(rdat, 16'hffff)
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0201)
    i_preamble_suppress = 1'b0;
  endtask
  task automatic t_clk_en();
    wr(`PEI_REG_MASK, 16'h0003);
    @(posedge i_clk_sys) #1;
    clk_en = 1'b0;
    pulse(11'h002);
    clk_en = 1'b1;
    `CHK(irq_n, 1'b1)
    rd(`PEI_REG_STAT); `CHK(rdat, 16'h0000)
  endtask
  task automatic t_refuse();
    wr(`PEI_REG_MASK, 16'h0011);
    pei_smc_model_inst.frame(`PEI_OP_WR, 5'h04, `PEI_REG_MASK, 16'h0000, rdat, 1'b1);
    wr(5'h1f, 16'hffff);
    rd(`PEI_REG_MASK); `CHK(rdat, 16'h0011)
    pei_smc_model_inst.frame(`PEI_OP_RD, 5'h04, `PEI_REG_MASK, 16'h0000, rdat, 1'b1);
    `CHK(rdat, 16'hffff)
    rd(5'h1f); `CHK(rdat, 16'h0000)
  endtask

  // cut a hang short
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk_sys);
    #1 i_sys_rst = 1'b0;
    #37;
    t_reset();
    t_events();
    t_gate();
    t_force();
    t_sync();
    t_persist();
    t_suppress();
    t_clk_en();
    t_refuse();
    summarize();
  end
endmodule // tb_top
